// File: verilog/mmq_regs.svh
`ifndef MMQ_REGS_SVH
`define MMQ_REGS_SVH
// Behaviour
// [RULE1] Simple inbox rings over fixed-size frames
// [RULE2] Simple inbox full: pointers meet, retry
// [RULE3] Simple inbox posting raises processor interrupt
// [RULE4] Four data mailboxes chosen by mailbox field
// [RULE5] Doorbells go to one separate mailbox
// [RULE6] Free and post FIFO pair per priority
// [RULE7] First transaction takes free-list tail frame
// [RULE8] Retry other sender or letter while assembling
// [RULE9] Payload written at frame base plus offset
// [RULE10] Completed message pushed onto post list
// [RULE11] Post to empty post list interrupts processor
// [RULE12] Mailbox busy between last transaction and commit
// [RULE13] Processor pops post list at tail
// [RULE14] Processor returns frames at free-list head
// [RULE15] Free list empty when pointers equal: retry
// [RULE16] Post list empty when pointers equal
// [RULE17] List underflow is fatal, reported in status
// [RULE18] Outbound read gives head or full pattern
// [RULE19] Processor writes descriptor before signalling
// [RULE20] Outbound write advances head, queues message
// [RULE21] Outbound hardware sends tail message to target
// [RULE22] One outbound queue per priority level
// [RULE23] Length is count minus one, segment zero-based
// [RULE24] Standard size places every segment in memory
// [RULE25] Letter tells four concurrent messages apart; the code keeps one message per mailbox and retries any other letter
// [RULE26] Pointers wrap to first entry of region

// ----------------------------------------
// Sizes
// ----------------------------------------
`define MMQ_DEPTH 8
`define MMQ_PTR_W 3
`define MMQ_PTR_ONE 4'h1
`define MMQ_NPRIO 2
`define MMQ_NMBOX 4
`define MMQ_DW 32

// ----------------------------------------
// Local memory layout
// ----------------------------------------
`define MMQ_FRAME_BYTES 32'h0000_1000
`define MMQ_OB_BASE 32'h0001_0000
`define MMQ_OB_PRIO_STRIDE 32'h0000_8000
`define MMQ_DB_BASE 32'h0002_0000
`define MMQ_DB_FRAME_BYTES 32'h0000_0008
`define MMQ_FULL_PATTERN 32'hFFFF_FFFF

// ----------------------------------------
// Status fields
// ----------------------------------------
`define MMQ_FATAL_FREE 0
`define MMQ_FATAL_POST 1
`endif

// File: verilog/mmq_pkg.sv
`include "mmq_regs.svh"
package mmq_pkg;
  typedef logic [`MMQ_DW-1:0] mmq_addr_t;
  typedef enum logic [1:0] {
    MMQ_TX_IDLE = 2'h1,
    MMQ_TX_SEND = 2'h2
  } mmq_tx_state_e;
endpackage

// File: verilog/mmq_ring_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmq_regs.svh"
interface mmq_ring_if;
  logic push;
  logic [`MMQ_DW-1:0] push_data;
  logic pop;
  logic [`MMQ_DW-1:0] pop_data;
  logic empty;
  logic full;
  logic underflow;
  logic [`MMQ_PTR_W-1:0] head_idx;
  logic [`MMQ_PTR_W-1:0] tail_idx;
  modport ring(input push, push_data, pop,
    output pop_data, empty, full, underflow, head_idx, tail_idx);
  modport fill(output push, push_data,
    input empty, full, head_idx);
  modport drain(output pop,
    input pop_data, empty, underflow, tail_idx);
endinterface
`default_nettype wire

// File: verilog/mmq_ring.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmq_regs.svh"
module mmq_ring
  import mmq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Queue
  mmq_ring_if.ring q
);
  logic [`MMQ_DW-1:0] mem [`MMQ_DEPTH];
  logic [`MMQ_PTR_W:0] head_r;
  logic [`MMQ_PTR_W:0] tail_r;
  logic do_push;
  logic do_pop;

  assign q.head_idx = head_r[`MMQ_PTR_W-1:0];
  assign q.tail_idx = tail_r[`MMQ_PTR_W-1:0];
  assign q.empty = (head_r == tail_r); // [RULE15] [RULE16]
  assign q.full = (q.head_idx == q.tail_idx) &&
    (head_r[`MMQ_PTR_W] != tail_r[`MMQ_PTR_W]); // [RULE2]
  assign q.pop_data = mem[q.tail_idx];
  assign q.underflow = ce_in && q.pop && q.empty; // [RULE17]
  assign do_push = ce_in && q.push && !q.full;
  assign do_pop = ce_in && q.pop && !q.empty;

  // ----------------------------------------
  // Pointers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      head_r <= '0;
      tail_r <= '0;
    end else begin
      if (do_push) begin
        head_r <= head_r + `MMQ_PTR_ONE; // [RULE26]
      end
      if (do_pop) begin
        tail_r <= tail_r + `MMQ_PTR_ONE; // [RULE26]
      end
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[q.head_idx] <= q.push_data;
    end
  end
endmodule
`default_nettype wire

// File: verilog/mmq_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmq_regs.svh"
module mmq_tx
  import mmq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Outbound queues, high and low priority
  mmq_ring_if.drain q_hi,
  mmq_ring_if.drain q_lo,
  // Link
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [`MMQ_DW-1:0] tx_frame_out,
  output logic [15:0] tx_target_out,
  output logic tx_prio_out
);
  mmq_tx_state_e state_r;
  logic take_hi;
  logic take_lo;

  assign take_hi = ce_in && (state_r == MMQ_TX_IDLE) && !q_hi.empty;
  assign take_lo = ce_in && (state_r == MMQ_TX_IDLE) && q_hi.empty &&
    !q_lo.empty;
  assign q_hi.pop = take_hi; // [RULE21]
  assign q_lo.pop = take_lo; // [RULE21]

  // ----------------------------------------
  // Sender state
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= MMQ_TX_IDLE;
      tx_valid_out <= 1'b0;
      tx_frame_out <= '0;
      tx_target_out <= '0;
      tx_prio_out <= 1'b0;
    end else if (ce_in) begin
      unique case (state_r)
        MMQ_TX_IDLE: begin
          if (take_hi || take_lo) begin
            state_r <= MMQ_TX_SEND;
            tx_valid_out <= 1'b1;
            tx_prio_out <= take_hi;
            tx_target_out <= take_hi ? q_hi.pop_data[15:0] :
              q_lo.pop_data[15:0]; // [RULE21]
            tx_frame_out <= `MMQ_OB_BASE +
              (take_hi ? `MMQ_OB_PRIO_STRIDE : '0) +
              32'(take_hi ? q_hi.tail_idx : q_lo.tail_idx) *
              `MMQ_FRAME_BYTES;
          end
        end
        MMQ_TX_SEND: begin
          if (tx_ready_in) begin
            state_r <= MMQ_TX_IDLE;
            tx_valid_out <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verilog/mmq_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmq_regs.svh"
module mmq_top
  import mmq_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic CLK_EN_IN,
  // Inbound link transactions
  input wire logic RX_VALID_IN,
  input wire logic RX_DOORBELL_IN,
  input wire logic [15:0] RX_SENDER_IN,
  input wire logic [1:0] RX_MBOX_IN,
  input wire logic [1:0] RX_LETTER_IN,
  input wire logic RX_PRIO_IN,
  input wire logic [3:0] RX_MSGLEN_IN,
  input wire logic [3:0] RX_MSGSEG_IN,
  input wire logic [8:0] RX_SSIZE_IN,
  input wire logic [15:0] RX_INFO_IN,
  input wire logic [63:0] RX_DATA_IN,
  output logic RX_ACCEPT_OUT,
  output logic RX_RETRY_OUT,
  // Local memory write port
  output logic MEM_WR_OUT,
  output logic [`MMQ_DW-1:0] MEM_ADDR_OUT,
  output logic [63:0] MEM_DATA_OUT,
  // Local processor requests
  input wire logic PROC_PRIO_IN,
  input wire logic PROC_POST_POP_IN,
  input wire logic PROC_FREE_PUSH_IN,
  input wire logic [`MMQ_DW-1:0] PROC_FREE_ADDR_IN,
  input wire logic PROC_DB_POP_IN,
  input wire logic PROC_OB_RD_IN,
  input wire logic PROC_OB_WR_IN,
  input wire logic [15:0] PROC_OB_TARGET_IN,
  output logic PROC_RD_VALID_OUT,
  output logic [`MMQ_DW-1:0] PROC_RD_DATA_OUT,
  // Processor events and status
  output logic MSG_IRQ_OUT,
  output logic DB_IRQ_OUT,
  output logic [`MMQ_NPRIO-1:0] POST_PENDING_OUT,
  output logic FATAL_OUT,
  output logic [1:0] FATAL_CODE_OUT,
  // Outbound link
  input wire logic TX_READY_IN,
  output logic TX_VALID_OUT,
  output logic [`MMQ_DW-1:0] TX_FRAME_OUT,
  output logic [15:0] TX_TARGET_OUT,
  output logic TX_PRIO_OUT
);
  // ----------------------------------------
  // Queues
  // ----------------------------------------
  mmq_ring_if free_if[`MMQ_NPRIO] ();
  mmq_ring_if post_if[`MMQ_NPRIO] ();
  mmq_ring_if ob_if[`MMQ_NPRIO] ();
  mmq_ring_if db_if ();

  logic [`MMQ_NPRIO-1:0] free_empty;
  logic [`MMQ_NPRIO-1:0] post_empty;
  logic [`MMQ_NPRIO-1:0] ob_full;
  logic [`MMQ_NPRIO-1:0] free_uf;
  logic [`MMQ_NPRIO-1:0] post_uf;
  mmq_addr_t free_head [`MMQ_NPRIO];
  mmq_addr_t post_tail [`MMQ_NPRIO];
  mmq_addr_t ob_head [`MMQ_NPRIO];

  // Mailbox assembly slots
  logic [`MMQ_NMBOX-1:0] slot_act_r;
  logic [15:0] slot_src_r [`MMQ_NMBOX];
  logic [1:0] slot_let_r [`MMQ_NMBOX];
  logic slot_prio_r [`MMQ_NMBOX];
  logic [3:0] slot_len_r [`MMQ_NMBOX];
  logic [3:0] slot_cnt_r [`MMQ_NMBOX];
  mmq_addr_t slot_base_r [`MMQ_NMBOX];

  // Commit stage
  logic commit_r;
  logic [1:0] commit_mbx_r;
  logic commit_prio_r;
  mmq_addr_t commit_base_r;

  // Inbound decision
  logic rx_data;
  logic rx_db;
  logic slot_hit;
  logic slot_busy;
  logic accept_data;
  logic accept_db;
  logic first;
  logic last;
  logic msg_prio;
  logic [3:0] msg_len;
  logic [3:0] msg_cnt;
  mmq_addr_t msg_base;
  mmq_addr_t seg_addr;
  mmq_addr_t db_addr;

  genvar p;
  generate
    for (p = 0; p < `MMQ_NPRIO; p++) begin : g_prio
      mmq_ring u_free (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESET_N_IN),
        .ce_in(CLK_EN_IN),
        .q(free_if[p])
      ); // [RULE6]
      mmq_ring u_post (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESET_N_IN),
        .ce_in(CLK_EN_IN),
        .q(post_if[p])
      ); // [RULE6]
      mmq_ring u_ob (
        .clk_in(CLOCK_IN),
        .rst_n_in(RESET_N_IN),
        .ce_in(CLK_EN_IN),
        .q(ob_if[p])
      ); // [RULE22]
      assign free_empty[p] = free_if[p].empty;
      assign free_head[p] = free_if[p].pop_data;
      assign free_uf[p] = free_if[p].underflow;
      assign post_empty[p] = post_if[p].empty;
      assign post_tail[p] = post_if[p].pop_data;
      assign post_uf[p] = post_if[p].underflow;
      assign ob_full[p] = ob_if[p].full;
      assign ob_head[p] = `MMQ_OB_BASE +
        (p != 0 ? `MMQ_OB_PRIO_STRIDE : '0) +
        32'(ob_if[p].head_idx) * `MMQ_FRAME_BYTES;
      // Frame taken from the free-list tail on a first transaction
      assign free_if[p].pop = first && (RX_PRIO_IN == 1'(p)); // [RULE7]
      // Frames returned by the processor
      assign free_if[p].push = PROC_FREE_PUSH_IN &&
        (PROC_PRIO_IN == 1'(p)); // [RULE14]
      assign free_if[p].push_data = PROC_FREE_ADDR_IN;
      assign post_if[p].push = commit_r &&
        (commit_prio_r == 1'(p)); // [RULE10]
      assign post_if[p].push_data = commit_base_r;
      assign post_if[p].pop = PROC_POST_POP_IN &&
        (PROC_PRIO_IN == 1'(p)); // [RULE13]
      assign ob_if[p].push = PROC_OB_WR_IN &&
        (PROC_PRIO_IN == 1'(p)); // [RULE20]
      assign ob_if[p].push_data = {16'h0000, PROC_OB_TARGET_IN};
    end
  endgenerate

  mmq_ring u_db (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESET_N_IN),
    .ce_in(CLK_EN_IN),
    .q(db_if)
  ); // [RULE1] [RULE5]
  assign db_if.push = accept_db;
  assign db_if.push_data = {16'h0000, RX_INFO_IN};
  assign db_if.pop = PROC_DB_POP_IN && !PROC_POST_POP_IN;

  mmq_tx u_tx (
    .clk_in(CLOCK_IN),
    .rst_n_in(RESET_N_IN),
    .ce_in(CLK_EN_IN),
    .q_hi(ob_if[1]),
    .q_lo(ob_if[0]),
    .tx_ready_in(TX_READY_IN),
    .tx_valid_out(TX_VALID_OUT),
    .tx_frame_out(TX_FRAME_OUT),
    .tx_target_out(TX_TARGET_OUT),
    .tx_prio_out(TX_PRIO_OUT)
  ); // [RULE21] [RULE22]

  // ----------------------------------------
  // Inbound decision
  // ----------------------------------------
  assign rx_data = RX_VALID_IN && !RX_DOORBELL_IN;
  assign rx_db = RX_VALID_IN && RX_DOORBELL_IN;
  assign slot_hit = (slot_src_r[RX_MBOX_IN] == RX_SENDER_IN) &&
    (slot_let_r[RX_MBOX_IN] == RX_LETTER_IN); // [RULE25]
  assign slot_busy = commit_r && (commit_mbx_r == RX_MBOX_IN); // [RULE12]
  assign accept_data = rx_data && !slot_busy &&
    (slot_act_r[RX_MBOX_IN] ? slot_hit :
    !free_empty[RX_PRIO_IN]); // [RULE4] [RULE8] [RULE15]
  assign first = accept_data && !slot_act_r[RX_MBOX_IN]; // [RULE7]
  assign msg_prio = first ? RX_PRIO_IN : slot_prio_r[RX_MBOX_IN];
  assign msg_len = first ? RX_MSGLEN_IN : slot_len_r[RX_MBOX_IN];
  assign msg_cnt = first ? 4'h0 : slot_cnt_r[RX_MBOX_IN];
  assign last = accept_data && (msg_cnt == msg_len); // [RULE23]
  assign msg_base = first ? free_head[RX_PRIO_IN] :
    slot_base_r[RX_MBOX_IN];
  assign seg_addr = msg_base +
    32'(RX_MSGSEG_IN) * 32'(RX_SSIZE_IN); // [RULE9] [RULE24]
  assign accept_db = rx_db && !db_if.full; // [RULE2] [RULE5]
  assign db_addr = `MMQ_DB_BASE +
    32'(db_if.head_idx) * `MMQ_DB_FRAME_BYTES; // [RULE1]

  // ----------------------------------------
  // Assembly slots, one per mailbox
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `MMQ_NMBOX; g++) begin : g_mbox
      always_ff @(posedge CLOCK_IN) begin
        if (!RESET_N_IN) begin
          slot_act_r[g] <= 1'b0;
          slot_src_r[g] <= '0;
          slot_let_r[g] <= '0;
          slot_prio_r[g] <= 1'b0;
          slot_len_r[g] <= '0;
          slot_cnt_r[g] <= '0;
          slot_base_r[g] <= '0;
        end else if (CLK_EN_IN && accept_data &&
            (RX_MBOX_IN == 2'(g))) begin
          slot_act_r[g] <= !last; // [RULE8]
          slot_cnt_r[g] <= msg_cnt + 4'h1;
          if (first) begin
            slot_src_r[g] <= RX_SENDER_IN;
            slot_let_r[g] <= RX_LETTER_IN;
            slot_prio_r[g] <= RX_PRIO_IN;
            slot_len_r[g] <= RX_MSGLEN_IN;
            slot_base_r[g] <= free_head[RX_PRIO_IN]; // [RULE7]
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Commit of finished messages
  // ----------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      commit_r <= 1'b0;
      commit_mbx_r <= '0;
      commit_prio_r <= 1'b0;
      commit_base_r <= '0;
      MSG_IRQ_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      commit_r <= last; // [RULE12]
      commit_mbx_r <= RX_MBOX_IN;
      commit_prio_r <= msg_prio;
      commit_base_r <= msg_base;
      MSG_IRQ_OUT <= commit_r && post_empty[commit_prio_r]; // [RULE11]
    end
  end

  // ----------------------------------------
  // Link answer and memory writes
  // ----------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      RX_ACCEPT_OUT <= 1'b0;
      RX_RETRY_OUT <= 1'b0;
      MEM_WR_OUT <= 1'b0;
      MEM_ADDR_OUT <= '0;
      MEM_DATA_OUT <= '0;
      DB_IRQ_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      RX_ACCEPT_OUT <= accept_data || accept_db;
      RX_RETRY_OUT <= RX_VALID_IN &&
        !(accept_data || accept_db); // [RULE2] [RULE8] [RULE15]
      MEM_WR_OUT <= accept_data || accept_db; // [RULE9]
      MEM_ADDR_OUT <= accept_db ? db_addr : seg_addr;
      MEM_DATA_OUT <= accept_db ? {48'h0, RX_INFO_IN} : RX_DATA_IN;
      DB_IRQ_OUT <= accept_db; // [RULE3]
    end
  end

  // ----------------------------------------
  // Processor reads
  // ----------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      PROC_RD_VALID_OUT <= 1'b0;
      PROC_RD_DATA_OUT <= '0;
    end else if (CLK_EN_IN) begin
      PROC_RD_VALID_OUT <= PROC_POST_POP_IN || PROC_DB_POP_IN ||
        PROC_OB_RD_IN;
      if (PROC_POST_POP_IN) begin
        PROC_RD_DATA_OUT <= post_tail[PROC_PRIO_IN]; // [RULE13]
      end else if (PROC_DB_POP_IN) begin
        PROC_RD_DATA_OUT <= db_if.pop_data;
      end else if (ob_full[PROC_PRIO_IN]) begin
        PROC_RD_DATA_OUT <= `MMQ_FULL_PATTERN; // [RULE18]
      end else begin
        PROC_RD_DATA_OUT <= ob_head[PROC_PRIO_IN]; // [RULE18] [RULE19]
      end
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (!RESET_N_IN) begin
      POST_PENDING_OUT <= '0;
      FATAL_OUT <= 1'b0;
      FATAL_CODE_OUT <= '0;
    end else if (CLK_EN_IN) begin
      POST_PENDING_OUT <= ~post_empty; // [RULE16]
      if (|free_uf) begin
        FATAL_CODE_OUT[`MMQ_FATAL_FREE] <= 1'b1; // [RULE17]
      end
      if (|post_uf) begin
        FATAL_CODE_OUT[`MMQ_FATAL_POST] <= 1'b1; // [RULE17]
      end
      if ((|free_uf) || (|post_uf)) begin
        FATAL_OUT <= 1'b1; // [RULE17]
      end
    end
  end
endmodule
`default_nettype wire

// File: test/mmq_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmq_regs.svh"
module mmq_top_sva (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  // Inbound link and memory
  input wire logic RX_VALID_IN,
  input wire logic RX_DOORBELL_IN,
  input wire logic RX_ACCEPT_OUT,
  input wire logic RX_RETRY_OUT,
  input wire logic MEM_WR_OUT,
  // Processor side
  input wire logic PROC_PRIO_IN,
  input wire logic PROC_POST_POP_IN,
  input wire logic PROC_OB_RD_IN,
  input wire logic PROC_RD_VALID_OUT,
  input wire logic MSG_IRQ_OUT,
  input wire logic DB_IRQ_OUT,
  input wire logic [`MMQ_NPRIO-1:0] POST_PENDING_OUT,
  input wire logic FATAL_OUT,
  input wire logic [1:0] FATAL_CODE_OUT,
  // Outbound link
  input wire logic TX_READY_IN,
  input wire logic TX_VALID_OUT,
  input wire logic [`MMQ_DW-1:0] TX_FRAME_OUT,
  input wire logic [15:0] TX_TARGET_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_rx_one_answer: assert property (
    RX_VALID_IN |=> RX_ACCEPT_OUT != RX_RETRY_OUT)
    else $error("inbound request not answered exactly once");
  a_rx_no_request: assert property (
    !RX_VALID_IN |=> !RX_ACCEPT_OUT && !RX_RETRY_OUT)
    else $error("answer without inbound request");
  a_accept_writes: assert property (
    RX_ACCEPT_OUT |-> MEM_WR_OUT)
    else $error("accepted transaction not written");
  a_write_has_cause: assert property (
    MEM_WR_OUT |-> RX_ACCEPT_OUT)
    else $error("memory write without acceptance");
  a_bell_interrupt: assert property (
    RX_ACCEPT_OUT && $past(RX_DOORBELL_IN) |-> ##[0:2] DB_IRQ_OUT)
    else $error("doorbell posted without interrupt");
  a_msg_irq_cause: assert property (
    MSG_IRQ_OUT |-> $past(RX_ACCEPT_OUT) ##1 POST_PENDING_OUT != 2'h0)
    else $error("message interrupt without posted message");
  a_tx_holds: assert property (
    TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_FRAME_OUT)
      && $stable(TX_TARGET_OUT))
    else $error("outbound transfer changed before acceptance");
  a_tx_gap: assert property (
    TX_VALID_OUT && TX_READY_IN |=> !TX_VALID_OUT)
    else $error("no idle cycle after outbound transfer");
  a_read_answer: assert property (
    PROC_POST_POP_IN || PROC_OB_RD_IN |=> PROC_RD_VALID_OUT)
    else $error("processor read not answered");
  a_fatal_sticky: assert property (
    FATAL_OUT |=> FATAL_OUT && $stable(FATAL_CODE_OUT))
    else $error("fatal status lost");
  a_underflow_fatal: assert property (
    PROC_POST_POP_IN && !MSG_IRQ_OUT && !POST_PENDING_OUT[PROC_PRIO_IN]
      |-> ##[1:2] FATAL_OUT && FATAL_CODE_OUT[1])
    else $error("post list underflow not fatal");
endmodule
`default_nettype wire

// File: test/mmq_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmq_link_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bench control
  input wire logic stall_in,
  // Outbound link
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic take_out
);
  logic [1:0] cnt_r;
  initial tx_ready_out = 1'b0;
  // Slow receiver: refuses one cycle in four, or all while stalled
  always @(posedge clk_in) begin
    cnt_r <= rst_n_in ? cnt_r + 2'h1 : 2'h0;
    tx_ready_out <= #1 rst_n_in && !stall_in && cnt_r != 2'h1;
  end
  assign take_out = tx_valid_in && tx_ready_out;
endmodule
`default_nettype wire

// File: test/mmq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmq_regs.svh"
module mmq_tb_top;
  import mmq_pkg::*;
  logic clk, rst_n, rv, rdb, rprio, pp, fp, obr, obw, prio, stall, prd, pv;
  logic pacc, acc, rty, mwr, rdv, mirq, dirq, fatal, txv, txr, txp, take, dp;
  logic [1:0] rmbx, rlet, pend, fcode;
  logic [3:0] rlen, rseg;
  logic [8:0] rss;
  logic [15:0] rsnd, tgt, info, txt;
  logic [31:0] seed, rnd;
  logic [63:0] rdat, mdat, pdat, pm;
  mmq_addr_t faddr, maddr, rdd, txf, paddr, prexp;
  mmq_addr_t fq[2][$], pq[2][$], sfr[4], dq[$];
  logic [47:0] ex[2][$];
  logic seen[$];
  int error_cnt, tests_run, cyc, dbn, obh[2];
  int act[4], ssnd[4], slet[4], sprio[4], scnt[4], slast[4];

  mmq_top i_dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(1'b1),
    .RX_VALID_IN(rv), .RX_DOORBELL_IN(rdb), .RX_SENDER_IN(rsnd),
    .RX_MBOX_IN(rmbx), .RX_LETTER_IN(rlet), .RX_PRIO_IN(rprio),
    .RX_MSGLEN_IN(rlen), .RX_MSGSEG_IN(rseg), .RX_SSIZE_IN(rss),
    .RX_INFO_IN(info), .RX_DATA_IN(rdat), .RX_ACCEPT_OUT(acc),
    .RX_RETRY_OUT(rty), .MEM_WR_OUT(mwr), .MEM_ADDR_OUT(maddr),
    .MEM_DATA_OUT(mdat), .PROC_PRIO_IN(prio), .PROC_POST_POP_IN(pp),
    .PROC_FREE_PUSH_IN(fp), .PROC_FREE_ADDR_IN(faddr),
    .PROC_DB_POP_IN(dp), .PROC_OB_RD_IN(obr), .PROC_OB_WR_IN(obw),
    .PROC_OB_TARGET_IN(tgt), .PROC_RD_VALID_OUT(rdv),
    .PROC_RD_DATA_OUT(rdd), .MSG_IRQ_OUT(mirq), .DB_IRQ_OUT(dirq),
    .POST_PENDING_OUT(pend), .FATAL_OUT(fatal), .FATAL_CODE_OUT(fcode),
    .TX_READY_IN(txr), .TX_VALID_OUT(txv), .TX_FRAME_OUT(txf),
    .TX_TARGET_OUT(txt), .TX_PRIO_OUT(txp));
  mmq_link_model i_link (.clk_in(clk), .rst_n_in(rst_n), .stall_in(stall),
    .tx_valid_in(txv), .tx_ready_out(txr), .take_out(take));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc++;
  always @(posedge clk) if (take) begin
    seen.push_back(txp);
    chk({txt, txf}, ex[txp].pop_front(), "frame");
  end
  initial begin
    #(25 * 3000);
    error_cnt++;
    end_sim();
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic step(input logic [4:0] op);
    @(posedge clk);
    #1;
    if (pv) begin
      chk(acc, pacc, "accept");
      chk(rty, !pacc, "retry");
      if (pacc) chk(maddr, paddr, "address");
      if (pacc) chk(mdat & pm, pdat & pm, "payload");
    end
    if (prd) chk(rdd, prexp, "read data");
    if (prd) chk(rdv, 1'b1, "read valid");
    {pv, prd, dp} = 3'h0;
    {rv, pp, fp, obr, obw} = op;
  endtask
  task automatic rx(input logic d, input logic [15:0] s, input int m, l, n,
                    input int g, input logic p, input int sz);
    step(5'h10);
    rnd = xs();
    {rdb, rsnd, rmbx, rlet, rprio} = {d, s, 2'(m), 2'(l), p};
    {rlen, rseg, rss, info} = {4'(n), 4'(g), 9'(sz), rnd[15:0]};
    rdat = {rnd, xs()};
    {pv, pdat} = {1'b1, d ? {48'h0, info} : rdat};
    pm = d ? 64'hFFFF : '1;
    if (d) pacc = dbn < 8;
    else if (cyc == slast[m] + 1) pacc = 0;
    else if (act[m] != 0) pacc = s == ssnd[m] && l == slet[m];
    else pacc = fq[p].size() > 0;
    if (pacc && d) begin
      paddr = `MMQ_DB_BASE + dbn * `MMQ_DB_FRAME_BYTES;
      dq.push_back({16'h0000, info});
      dbn++;
    end else if (pacc) begin
      if (act[m] == 0) begin
        {act[m], scnt[m]} = {32'd1, 32'd0};
        {ssnd[m], slet[m], sprio[m]} = {32'(s), l, 32'(p)};
        sfr[m] = fq[p].pop_front();
      end
      paddr = sfr[m] + g * sz;
      scnt[m]++;
      if (scnt[m] == n + 1) begin
        {act[m], slast[m]} = {32'd0, cyc};
        pq[sprio[m]].push_back(sfr[m]);
      end
    end
  endtask
  task automatic free_push(input logic p, input mmq_addr_t a);
    step(5'h04);
    {prio, faddr} = {p, a};
    if (fq[p].size() < `MMQ_DEPTH) fq[p].push_back(a);
  endtask
  task automatic post_pop(input logic p);
    step(5'h08);
    {prio, prd} = {p, 1'b1};
    prexp = pq[p].pop_front();
  endtask
  task automatic db_pop();
    step(5'h00);
    {dp, prd} = 2'h3;
    prexp = dq.pop_front();
  endtask
  task automatic ob_rd(input logic p, input mmq_addr_t e);
    step(5'h02);
    {prio, prd, prexp} = {p, 1'b1, e};
  endtask
  task automatic ob_wr(input logic p);
    step(5'h01);
    rnd = xs();
    {prio, tgt} = {p, rnd[31:16]};
    ex[p].push_back({tgt, `MMQ_OB_BASE + p * `MMQ_OB_PRIO_STRIDE
      + (obh[p] % `MMQ_DEPTH) * `MMQ_FRAME_BYTES});
    obh[p]++;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rv, rdb, rprio, pp, fp, obr, obw, prio, stall, prd, pv, dp} = '0;
    {rsnd, tgt, info, rmbx, rlet, rlen, rseg, rss, rdat, faddr} = '0;
    {seed, rst_n} = {32'hC628FDEF, 1'b0};
    slast = '{default: -5};
    repeat (5) @(posedge clk);
    #1 rst_n = 1;
    step(5'h00);
    chk({acc, rty, mwr, rdv, mirq, txv, fatal, pend}, '0, "reset");
    rx(0, 16'h0011, 0, 0, 0, 0, 0, 8);
    for (int i = 0; i < 9; i++) free_push(0, 32'h0010_0000 + i * 32'h1000);
    free_push(1, 32'h0020_0000);
    $display("Test free list finished");
    for (int i = 0; i < 4; i++) rx(0, 16'(xs()), i, 0, 0, 0, 0, 8);
    rx(0, 16'h0031, 0, 0, 0, 0, 1, 8);
    rx(0, 16'h0032, 3, 0, 0, 0, 1, 8);
    repeat (2) step(5'h00);
    for (int i = 0; i < 4; i++) post_pop(0);
    post_pop(1);
    $display("Test single messages finished");
    rx(0, 16'h0042, 1, 1, 2, 2, 0, 64);
    rx(0, 16'h0043, 1, 1, 2, 0, 0, 64);
    rx(0, 16'h0042, 1, 2, 2, 0, 0, 64);
    rx(0, 16'h0043, 2, 0, 0, 0, 0, 8);
    rx(0, 16'h0042, 1, 1, 2, 0, 0, 64);
    rx(0, 16'h0042, 1, 1, 2, 1, 0, 64);
    rx(0, 16'h0044, 1, 0, 0, 0, 0, 8);
    for (int i = 0; i < 9; i++) rx(1, 0, 0, 0, 0, 0, 0, 8);
    db_pop();
    $display("Test assembly and doorbells finished");
    ob_rd(0, `MMQ_OB_BASE);
    stall = 1;
    ob_wr(0);
    for (int i = 0; i < 3; i++) ob_wr(1);
    for (int i = 0; i < 8; i++) ob_wr(0);
    repeat (2) step(5'h00);
    ob_rd(0, `MMQ_FULL_PATTERN);
    ob_rd(1, `MMQ_OB_BASE + `MMQ_OB_PRIO_STRIDE + 3 * `MMQ_FRAME_BYTES);
    stall = 0;
    for (int k = 0; k < 200 && seen.size() < 12; k++) step(5'h00);
    chk(seen.size(), 12, "sent count");
    for (int i = 0; i < 12; i++) chk(seen[i], i inside {[1:3]}, "order");
    ob_rd(0, `MMQ_OB_BASE + `MMQ_FRAME_BYTES);
    $display("Test outbound finished");
    repeat (3) step(5'h00);
    step(5'h08);
    prio = 1;
    repeat (3) step(5'h00);
    chk({fatal, fcode[1]}, 2'h3, "underflow");
    $display("Test underflow finished");
    end_sim();
  end
endmodule

bind mmq_top mmq_top_sva i_sva (.CLOCK_IN(CLOCK_IN),
  .RESET_N_IN(RESET_N_IN), .RX_VALID_IN(RX_VALID_IN),
  .RX_DOORBELL_IN(RX_DOORBELL_IN), .RX_ACCEPT_OUT(RX_ACCEPT_OUT),
  .RX_RETRY_OUT(RX_RETRY_OUT), .MEM_WR_OUT(MEM_WR_OUT),
  .PROC_PRIO_IN(PROC_PRIO_IN), .PROC_POST_POP_IN(PROC_POST_POP_IN),
  .PROC_OB_RD_IN(PROC_OB_RD_IN), .PROC_RD_VALID_OUT(PROC_RD_VALID_OUT),
  .MSG_IRQ_OUT(MSG_IRQ_OUT), .DB_IRQ_OUT(DB_IRQ_OUT),
  .POST_PENDING_OUT(POST_PENDING_OUT), .FATAL_OUT(FATAL_OUT),
  .FATAL_CODE_OUT(FATAL_CODE_OUT), .TX_READY_IN(TX_READY_IN),
  .TX_VALID_OUT(TX_VALID_OUT), .TX_FRAME_OUT(TX_FRAME_OUT),
  .TX_TARGET_OUT(TX_TARGET_OUT));
`default_nettype wire
